/* File: logic/cache_test_pkg.sv */
// package: register map, field layout and encodings of the cache test port
package cache_test_pkg;
   localparam int unsigned AXI_ADDR_W = 12;
   localparam logic [11:0] OFS_DATA_PORT = 12'h000;
   localparam logic [11:0] OFS_TAG_VIEW = 12'h004;
   localparam logic [11:0] OFS_COMMAND = 12'h008;
   localparam logic [11:0] OFS_STATUS = 12'h00C;
   // command register fields
   localparam int unsigned CTL_LSB = 0;
   localparam int unsigned ENTRY_LSB = 2;
   localparam int unsigned INDEX_LSB = 4;
   localparam int unsigned SETSTATE_LSB = 17;
   localparam int unsigned EXT_BIT = 19;
   // tag view register fields
   localparam int unsigned TAG_LSB = 11;
   localparam int unsigned VALID_BIT = 10;
   localparam int unsigned LRU_LSB = 7;
   localparam int unsigned VLD_LSB = 3;
   localparam int unsigned ST_LSB = 20;
   localparam int unsigned STN_LSB = 29;
   // geometry
   localparam int unsigned IDX_W = 7;
   localparam int unsigned TAG_W = 21;
   localparam int unsigned LINE_W = 128;
   localparam int unsigned LADDR_W = 28;
   typedef enum logic [1:0] {
      CTL_BUFFER = 2'b00,
      CTL_WRITE = 2'b01,
      CTL_READ = 2'b10,
      CTL_FLUSH = 2'b11
   } ctl_t;
   typedef enum logic [1:0] {
      ST_INVALID = 2'b00,
      ST_EXCLUSIVE = 2'b01,
      ST_MODIFIED = 2'b10,
      ST_SHARED = 2'b11
   } line_state_t;
   // values after reset and counts
   localparam logic [2:0] LRU_RESET = 3'h0;
   localparam logic [31:0] CMD_RESET = 32'h0000_0000;
   localparam logic [1:0] STRAP_SETTLE = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: logic/cache_line_array.sv */
// cache storage: tags, line states, pseudo-lru bits and line data
`timescale 1ns/100ps
module cache_line_array #(
   parameter int unsigned IDX_W = cache_test_pkg::IDX_W,
   parameter int unsigned TAG_W = cache_test_pkg::TAG_W,
   parameter int unsigned LINE_W = cache_test_pkg::LINE_W
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [IDX_W-1:0] op_set,
   input wire logic [1:0] op_way,
   output logic [3:0][TAG_W-1:0] rd_tags,
   output logic [3:0][1:0] rd_states,
   output logic [2:0] rd_lru,
   output logic [LINE_W-1:0] rd_line,
   input wire logic wr_en,
   input wire logic [TAG_W-1:0] wr_tag,
   input wire logic [LINE_W-1:0] wr_line,
   input wire logic st_en,
   input wire logic [1:0] st_val,
   input wire logic touch,
   input wire logic clr_all
);
   import cache_test_pkg::*;

   localparam int unsigned SETS = 1 << IDX_W;

   if (IDX_W + TAG_W + 4 != 32 || LINE_W != 128) begin : g_bad
      $error("cache_line_array: geometry does not fit a 32-bit address");
   end

   typedef struct packed {
      logic [SETS-1:0][3:0][TAG_W-1:0] tag;
      logic [SETS-1:0][3:0][1:0] st;
      logic [SETS-1:0][2:0] lru;
      logic [SETS-1:0][3:0][LINE_W-1:0] data;
   } arr_t;

   arr_t q;
   arr_t d;

   // tree bits point away from the way just used
   function automatic logic [2:0] plru_next(input logic [2:0] l,
                                            input logic [1:0] w);
      logic [2:0] r;
      r = l;
      r[0] = ~w[1];
      if (!w[1]) begin
         r[1] = ~w[0];
      end else begin
         r[2] = ~w[0];
      end
      return r;
   endfunction

   assign rd_tags = q.tag[op_set];
   assign rd_states = q.st[op_set];
   assign rd_lru = q.lru[op_set];
   assign rd_line = q.data[op_set][op_way];

   always_comb begin
      d = q;
      if (wr_en) begin
         d.tag[op_set][op_way] = wr_tag;
         d.data[op_set][op_way] = wr_line;
      end
      if (st_en) begin
         d.st[op_set][op_way] = st_val;
      end
      if (touch) begin
         d.lru[op_set] = plru_next(q.lru[op_set], op_way);
      end
      if (clr_all) begin
         d.st = '0;
         for (int s = 0; s < SETS; s++) begin
            d.lru[s] = LRU_RESET;
         end
      end
   end

   // all states invalid and lru at its starting point after reset
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule

/* File: logic/cache_test_register_access.sv */
// cache test register access: axi4-lite registers, test ops, write-back
// Notes on behaviour
// - command code 10 reads the line chosen by index and entry fields.
// - a read loads tag of entry plus lru and valid bits of set.
// - a read copies the 128 line bits into the read buffer.
// - code 00 plus entry returns one read buffer doubleword at data port.
// - in write-back mode ext bit 1 makes tag view show line states.
// - ext is zero for cache reads and writes; bits 31-11 are tag.
// - with code 00, data port writes fill the slot chosen by entry.
// - a cache write uses only tag and valid bit of the view register.
// - write-back mode takes line state from the set-state field.
// - code 01 writes fill buffer and tag at index and entry.
// - write-through mode takes validity from the view valid bit.
// - code 11 flushes alike in both modes, other fields ignored.
// - a flush clears every lru, valid and line state bit.
// - reset clears all line states and sets lru starting state.
// - policy strap at reset: low write-through, high write-back.
// - in write-back mode a snoop seen while idle that hits a modified line writes it back.
// - flush pin or instruction bursts out modified lines, then done.
// - seven-bit index picks one of 128 sets, entry one of four ways.
// - line states: 00 invalid, 01 exclusive, 10 modified, 11 shared.
// - per-set valid bits read set for exclusive, modified or shared.
`timescale 1ns/100ps
module cache_test_register_access (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [cache_test_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [cache_test_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic cache_policy_strap,
   input wire logic snoop_address_strobe_n,
   input wire logic [cache_test_pkg::LADDR_W-1:0] snoop_line_addr,
   input wire logic flush_req_n,
   input wire logic writeback_invalidate_instr,
   output logic wb_valid,
   input wire logic wb_ready,
   output logic [31:0] wb_addr,
   output logic [31:0] wb_data,
   output logic wb_last,
   output logic flush_done,
   output logic write_back_mode
);
   import cache_test_pkg::*;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_SCAN = 3'b001,
      S_SNPLD = 3'b010,
      S_BURST = 3'b011,
      S_FINISH = 3'b100
   } fsm_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic aw_full;
      logic w_full;
      logic [AXI_ADDR_W-1:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [31:0] cmd;
      logic [TAG_W-1:0] view_tag;
      logic view_valid;
      logic [2:0] view_lru;
      logic [3:0] view_vld;
      logic [7:0] view_st;
      logic [3:0][31:0] fill_buf;
      logic [LINE_W-1:0] read_buf;
      logic [2:0] strap_s;
      logic [2:0] snp_s;
      logic [2:0] fl_s;
      logic [2:0][LADDR_W-1:0] addr_s;
      logic snp_lvl;
      logic fl_lvl;
      logic [1:0] strap_cnt;
      logic strap_done;
      logic wb_mode;
      logic flush_pend;
      fsm_t state;
      logic [IDX_W+1:0] scan_pos;
      logic [1:0] word;
      logic [LINE_W-1:0] line;
      logic [LADDR_W-1:0] line_addr;
      logic from_snoop;
      logic [1:0] snp_way;
      logic wb_valid;
      logic [31:0] wb_addr;
      logic [31:0] wb_data;
      logic wb_last;
      logic flush_done;
   } state_t;

   state_t q;
   state_t d;

   logic [3:0][TAG_W-1:0] rd_tags;
   logic [3:0][1:0] rd_states;
   logic [2:0] rd_lru;
   logic [LINE_W-1:0] rd_line;
   logic [IDX_W-1:0] op_set;
   logic [1:0] op_way;
   logic wr_en;
   logic st_en;
   logic [1:0] st_val;
   logic touch;
   logic clr_all;
   logic [31:0] new_cmd;
   logic snp_new;
   logic fl_new;
   logic snp_evt;
   logic fl_evt;
   logic idle_ok;
   logic do_wr;

   ////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   // {hit, register number}; only aligned words of the map answer
   function automatic logic [2:0] reg_decode(
      input logic [AXI_ADDR_W-1:0] a);
      logic [2:0] r;
      r = 3'h0;
      if (a == OFS_DATA_PORT) begin
         r = 3'h4;
      end else if (a == OFS_TAG_VIEW) begin
         r = 3'h5;
      end else if (a == OFS_COMMAND) begin
         r = 3'h6;
      end else if (a == OFS_STATUS) begin
         r = 3'h7;
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // events and array addressing, all from registered state

   // ext and set-state do not exist in write-through mode
   always_comb begin
      new_cmd = merge(q.cmd, q.w_data, q.w_strb);
      if (!q.wb_mode) begin
         new_cmd[EXT_BIT] = 1'b0;
         new_cmd[SETSTATE_LSB +: 2] = 2'b00;
      end
   end

   // a pin change counts once the second and third stages agree
   assign snp_new = (q.snp_s[1] == q.snp_s[2]) ? q.snp_s[2] : q.snp_lvl;
   assign fl_new = (q.fl_s[1] == q.fl_s[2]) ? q.fl_s[2] : q.fl_lvl;
   // snoops are only looked at when idle; one arriving mid-burst is missed
   assign snp_evt = q.state == S_IDLE && q.wb_mode && q.strap_done &&
                    snp_new && !q.snp_lvl;
   assign fl_evt = fl_new && !q.fl_lvl;
   assign idle_ok = q.state == S_IDLE && q.strap_done && !snp_evt &&
                    !q.flush_pend;
   assign do_wr = q.aw_full && q.w_full && !q.bvalid && idle_ok;

   always_comb begin
      op_set = new_cmd[INDEX_LSB +: IDX_W];
      op_way = new_cmd[ENTRY_LSB +: 2];
      if (q.state == S_SCAN) begin
         op_set = q.scan_pos[IDX_W+1:2];
         op_way = q.scan_pos[1:0];
      end else if (q.state == S_SNPLD || q.state == S_BURST) begin
         op_set = q.line_addr[IDX_W-1:0];
         op_way = q.snp_way;
      end else if (snp_evt) begin
         op_set = q.addr_s[2][IDX_W-1:0];
      end
   end

   cache_line_array #(
      .IDX_W(IDX_W),
      .TAG_W(TAG_W),
      .LINE_W(LINE_W)
   ) u_array (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .op_set(op_set),
      .op_way(op_way),
      .rd_tags(rd_tags),
      .rd_states(rd_states),
      .rd_lru(rd_lru),
      .rd_line(rd_line),
      .wr_en(wr_en),
      .wr_tag(q.view_tag),
      .wr_line(q.fill_buf),
      .st_en(st_en),
      .st_val(st_val),
      .touch(touch),
      .clr_all(clr_all)
   );

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      logic [31:0] m;
      logic [31:0] tv;
      logic [3:0] hit;
      logic load;
      logic [IDX_W+1:0] last_pos;
      m = '0;
      tv = '0;
      hit = '0;
      load = 1'b0;
      last_pos = '1;
      d = q;
      wr_en = 1'b0;
      st_en = 1'b0;
      st_val = ST_INVALID;
      touch = 1'b0;
      clr_all = 1'b0;
      d.flush_done = 1'b0;

      // pin synchronisers; active-low pins are inverted ahead of stage one
      d.strap_s = {q.strap_s[1:0], cache_policy_strap};
      d.snp_s = {q.snp_s[1:0], ~snoop_address_strobe_n};
      d.fl_s = {q.fl_s[1:0], ~flush_req_n};
      d.addr_s = {q.addr_s[1:0], snoop_line_addr};
      d.snp_lvl = snp_new;
      d.fl_lvl = fl_new;

      // mode is caught once after reset release, then held
      if (!q.strap_done) begin
         if (q.strap_cnt != STRAP_SETTLE) begin
            d.strap_cnt = q.strap_cnt + 2'h1;
         end else if (q.strap_s[1] == q.strap_s[2]) begin
            d.wb_mode = q.strap_s[2];
            d.strap_done = 1'b1;
         end
      end

      // flush requests; a new request beats the clear of an old one
      d.flush_pend = (q.flush_pend &&
                      !(q.state == S_IDLE && q.strap_done && !snp_evt)) ||
                     fl_evt || writeback_invalidate_instr;

      // write-back engine
      case (q.state)
         S_IDLE: begin
            if (snp_evt) begin
               for (int w = 0; w < 4; w++) begin
                  hit[w] = rd_tags[w] == q.addr_s[2][LADDR_W-1:IDX_W] &&
                           rd_states[w] == ST_MODIFIED;
               end
               if (hit != 4'h0) begin
                  d.snp_way = hit[0] ? 2'd0 : hit[1] ? 2'd1 :
                              hit[2] ? 2'd2 : 2'd3;
                  d.line_addr = q.addr_s[2];
                  d.from_snoop = 1'b1;
                  d.state = S_SNPLD;
               end
            end else if (q.flush_pend && q.strap_done) begin
               d.scan_pos = '0;
               d.from_snoop = 1'b0;
               d.state = S_SCAN;
            end
         end
         S_SNPLD: begin
            load = 1'b1;
         end
         S_SCAN: begin
            if (rd_states[q.scan_pos[1:0]] == ST_MODIFIED) begin
               d.snp_way = q.scan_pos[1:0];
               d.line_addr = {rd_tags[q.scan_pos[1:0]],
                              q.scan_pos[IDX_W+1:2]};
               load = 1'b1;
            end else if (q.scan_pos == last_pos) begin
               d.state = S_FINISH;
            end else begin
               d.scan_pos = q.scan_pos + 1'b1;
            end
         end
         S_BURST: begin
            if (wb_ready && q.wb_valid) begin
               if (q.wb_last) begin
                  d.wb_valid = 1'b0;
                  d.wb_last = 1'b0;
                  // the copy in memory is now current, so the line is clean
                  st_en = 1'b1;
                  st_val = ST_EXCLUSIVE;
                  if (q.from_snoop) begin
                     d.from_snoop = 1'b0;
                     d.state = S_IDLE;
                  end else if (q.scan_pos == last_pos) begin
                     d.state = S_FINISH;
                  end else begin
                     d.scan_pos = q.scan_pos + 1'b1;
                     d.state = S_SCAN;
                  end
               end else begin
                  d.word = q.word + 2'h1;
                  d.wb_addr = {q.line_addr, d.word, 2'b00};
                  d.wb_data = q.line[32*d.word +: 32];
                  d.wb_last = q.word == 2'h2;
               end
            end
         end
         S_FINISH: begin
            // the special cycle follows only after all dirty lines left
            clr_all = 1'b1;
            d.flush_done = 1'b1;
            d.state = S_IDLE;
         end
         default: begin
            d.state = S_IDLE;
         end
      endcase

      if (load) begin
         d.line = rd_line;
         d.word = 2'h0;
         d.wb_valid = 1'b1;
         d.wb_last = 1'b0;
         d.wb_addr = {d.line_addr, 4'h0};
         d.wb_data = rd_line[31:0];
         d.state = S_BURST;
      end

      // axi write channels, taken in either order
      if (q.awready && s_axi_awvalid) begin
         d.aw_full = 1'b1;
         d.aw_addr = s_axi_awaddr;
      end
      if (q.wready && s_axi_wvalid) begin
         d.w_full = 1'b1;
         d.w_data = s_axi_wdata;
         d.w_strb = s_axi_wstrb;
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end

      // ops take effect at the same edge that raises bvalid
      if (do_wr) begin
         d.aw_full = 1'b0;
         d.w_full = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = RESP_OKAY;
         case (reg_decode(q.aw_addr))
            3'h4: begin
               if (q.cmd[CTL_LSB +: 2] == CTL_BUFFER) begin
                  m = merge(q.fill_buf[q.cmd[ENTRY_LSB +: 2]], q.w_data,
                            q.w_strb);
                  d.fill_buf[q.cmd[ENTRY_LSB +: 2]] = m;
               end
            end
            3'h5: begin
               m = merge({q.view_tag, q.view_valid, 10'h000}, q.w_data,
                         q.w_strb);
               d.view_tag = m[TAG_LSB +: TAG_W];
               d.view_valid = m[VALID_BIT];
            end
            3'h6: begin
               d.cmd = new_cmd;
               case (new_cmd[CTL_LSB +: 2])
                  CTL_READ: begin
                     d.view_tag = rd_tags[op_way];
                     d.view_valid = rd_states[op_way] != ST_INVALID;
                     d.view_lru = rd_lru;
                     for (int w = 0; w < 4; w++) begin
                        d.view_vld[w] = rd_states[w] != ST_INVALID;
                     end
                     d.view_st = rd_states;
                     d.read_buf = rd_line;
                  end
                  CTL_WRITE: begin
                     wr_en = 1'b1;
                     st_en = 1'b1;
                     touch = 1'b1;
                     if (q.wb_mode) begin
                        st_val = new_cmd[SETSTATE_LSB +: 2];
                     end else begin
                        st_val = q.view_valid ? ST_EXCLUSIVE :
                                 ST_INVALID;
                     end
                  end
                  CTL_FLUSH: begin
                     clr_all = 1'b1;
                  end
                  default: begin
                  end
               endcase
            end
            3'h7: begin
            end
            default: begin
               d.bresp = RESP_SLVERR;
            end
         endcase
      end

      // axi read channel
      if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      if (q.arready && s_axi_arvalid) begin
         d.rvalid = 1'b1;
         d.rresp = RESP_OKAY;
         d.rdata = '0;
         case (reg_decode(s_axi_araddr))
            3'h4: begin
               if (q.cmd[CTL_LSB +: 2] == CTL_BUFFER) begin
                  d.rdata = q.read_buf[32*q.cmd[ENTRY_LSB +: 2] +: 32];
               end
            end
            3'h5: begin
               if (q.wb_mode && q.cmd[EXT_BIT]) begin
                  tv[STN_LSB +: 2] =
                     q.view_st[{q.cmd[SETSTATE_LSB +: 2], 1'b0} +: 2];
                  tv[ST_LSB +: 8] = q.view_st;
               end else begin
                  tv[TAG_LSB +: TAG_W] = q.view_tag;
               end
               tv[VALID_BIT] = q.view_valid;
               tv[LRU_LSB +: 3] = q.view_lru;
               tv[VLD_LSB +: 4] = q.view_vld;
               d.rdata = tv;
            end
            3'h6: begin
               d.rdata = q.cmd;
            end
            3'h7: begin
               d.rdata = {28'h0000000, q.state != S_IDLE, q.flush_pend,
                          q.strap_done, q.wb_mode};
            end
            default: begin
               d.rresp = RESP_SLVERR;
            end
         endcase
      end

      // one write and one read outstanding at a time
      d.awready = !d.aw_full && !d.bvalid;
      d.wready = !d.w_full && !d.bvalid;
      d.arready = !d.rvalid;
   end

   ////////////////////////////////////////////////////////////////////////
   // registers; command starts at its reset value, all else zero

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign s_axi_awready = q.awready;
   assign s_axi_wready = q.wready;
   assign s_axi_bresp = q.bresp;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_arready = q.arready;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;
   assign s_axi_rvalid = q.rvalid;
   assign wb_valid = q.wb_valid;
   assign wb_addr = q.wb_addr;
   assign wb_data = q.wb_data;
   assign wb_last = q.wb_last;
   assign flush_done = q.flush_done;
   assign write_back_mode = q.wb_mode;
endmodule

/* File: tb/cache_test_register_access_chk.sv */
// port checker of the cache test block: axi answers and write-back beats
`timescale 1ns/100ps
module cache_test_register_access_chk (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic wb_valid,
   input wire logic wb_ready,
   input wire logic wb_last,
   input wire logic [31:0] wb_addr,
   input wire logic cache_policy_strap,
   input wire logic write_back_mode
);
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);
   property p_ra;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_ra: assert property (p_ra) else $error("no read answer");
   property p_rh;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
   endproperty
   a_rh: assert property (p_rh) else $error("rvalid dropped");
   property p_bh;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   a_bh: assert property (p_bh) else $error("bvalid dropped");
   property p_wh;
      wb_valid && !wb_ready |=> wb_valid && $stable(wb_addr);
   endproperty
   a_wh: assert property (p_wh) else $error("beat dropped");
   // beats of one line follow each other word by word
   property p_wn;
      wb_valid && wb_ready && !wb_last |=>
         wb_valid && wb_addr == $past(wb_addr) + 32'h4;
   endproperty
   a_wn: assert property (p_wn) else $error("beat order");
   property p_wf;
      $rose(wb_valid) |-> wb_addr[3:0] == 4'h0;
   endproperty
   a_wf: assert property (p_wf) else $error("line start");
   property p_wl;
      wb_valid |-> wb_last == (wb_addr[3:2] == 2'h3);
   endproperty
   a_wl: assert property (p_wl) else $error("last beat");
   property p_md;
      $rose(write_back_mode) |-> cache_policy_strap;
   endproperty
   a_md: assert property (p_md) else $error("mode strap");
   c_rd: cover property (s_axi_rvalid && s_axi_rready);
   c_wr: cover property (s_axi_bvalid && s_axi_bready);
   c_wb: cover property (wb_valid && wb_ready && wb_last);
endmodule
bind cache_test_register_access cache_test_register_access_chk i_chk (.*);

/* File: tb/cache_test_register_access_test.sv */
// self-checking bench of the cache test register access block
`timescale 1ns/100ps
module cache_test_register_access_test;
   import cache_test_pkg::*;
   logic ref_clk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, cache_policy_strap;
   logic snoop_address_strobe_n, flush_req_n, writeback_invalidate_instr;
   logic wb_valid, wb_ready, wb_last, flush_done, write_back_mode;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, wb_addr, wb_data, rd;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [3:0] s_axi_wstrb;
   logic [27:0] snoop_line_addr;
   localparam logic [20:0] TAG = 21'h0ABCD;
   localparam logic [27:0] LN = {TAG, 7'h05};
   int fails, tests_run, n;
   cache_test_register_access i_cache_test_register_access (.*);
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic finish_test;
      $display("compares %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, e, input string w);
      tests_run++;
      if (s !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", w, e, s);
      end
   endtask
   task automatic hang(input int lim);
      if (n >= lim) begin
         fails++;
         finish_test;
      end
   endtask
   function automatic logic [31:0] pat(input int e);
      return 32'h0101_0101 * 32'(e + 1);
   endfunction
   function automatic logic [31:0] cmd(input logic [1:0] st, c,
         input logic [6:0] ix, input logic [1:0] en);
      return {13'h0000, st, 6'h00, ix, en, c};
   endfunction
   // a flush scan may hold the response back for hundreds of cycles
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 2000 && !s_axi_bvalid; n++) begin
         @(posedge ref_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      hang(2000);
      chk(s_axi_bresp, RESP_OKAY, "bresp");
   endtask
   task automatic rdr(input logic [11:0] a, input logic [1:0] r);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 200 && !s_axi_rvalid; n++) begin
         @(posedge ref_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      rd = s_axi_rdata;
      hang(200);
      chk(s_axi_rresp, r, "rresp");
   endtask
   // the far side stalls every other cycle while a line drains
   task automatic beats;
      int b;
      b = 0;
      for (n = 0; n < 3000 && b < 4; n++) begin
         @(posedge ref_clk);
         if (wb_valid && wb_ready) begin
            chk(wb_addr, {LN, b[1:0], 2'h0}, "wb_addr");
            chk(wb_data, pat(b), "wb_data");
            b++;
         end
         wb_ready <= n[0];
      end
      hang(3000);
   endtask
   task automatic put_line(input logic [1:0] st);
      for (int e = 0; e < 4; e++) begin
         wr(OFS_COMMAND, cmd(2'h0, CTL_BUFFER, 7'h00, e[1:0]));
         wr(OFS_DATA_PORT, pat(e));
      end
      wr(OFS_TAG_VIEW, {TAG, 11'h7FF});
      wr(OFS_COMMAND, cmd(st, CTL_WRITE, 7'h05, 2'h2));
      wr(OFS_COMMAND, cmd(2'h0, CTL_READ, 7'h05, 2'h2));
      rdr(OFS_TAG_VIEW, RESP_OKAY);
   endtask
   task automatic t_reset;
      put_line(ST_INVALID);
      chk(rd, {TAG, 11'h620}, "wt view");
      rstn <= 1'b0;
      cache_policy_strap <= 1'b1;
      @(posedge ref_clk);
      rstn <= 1'b1;
      rdr(OFS_TAG_VIEW, RESP_OKAY);
      chk(rd, 32'h0000_0000, "tag view");
      rdr(12'h010, RESP_SLVERR);
      chk(write_back_mode, 1'b1, "mode");
      $display("reset test done");
   endtask
   task automatic t_read;
      put_line(ST_MODIFIED);
      chk(rd, {TAG, 11'h620}, "tag view");
      for (int e = 0; e < 4; e++) begin
         wr(OFS_COMMAND, cmd(2'h0, CTL_BUFFER, 7'h05, e[1:0]));
         rdr(OFS_DATA_PORT, RESP_OKAY);
         chk(rd, pat(e), "read buffer");
      end
      wr(OFS_COMMAND, cmd(2'h2, CTL_BUFFER, 7'h05, 2'h2) | 32'h0008_0000);
      rdr(OFS_TAG_VIEW, RESP_OKAY);
      chk(rd, 32'h4200_0620, "states");
      $display("read test done");
   endtask
   task automatic t_wback;
      snoop_address_strobe_n <= 1'b0;
      repeat (8) @(posedge ref_clk);
      snoop_address_strobe_n <= 1'b1;
      beats;
      put_line(ST_MODIFIED);
      flush_req_n <= 1'b0;
      repeat (8) @(posedge ref_clk);
      flush_req_n <= 1'b1;
      beats;
      for (n = 0; n < 2000 && !flush_done; n++) @(posedge ref_clk);
      hang(2000);
      $display("write-back test done");
   endtask
   task automatic t_flush;
      put_line(ST_SHARED);
      wr(OFS_COMMAND, cmd(2'h3, CTL_FLUSH, 7'h7F, 2'h1));
      wr(OFS_COMMAND, cmd(2'h0, CTL_READ, 7'h05, 2'h2));
      rdr(OFS_TAG_VIEW, RESP_OKAY);
      chk(rd[10:0], 11'h000, "flushed set");
      $display("flush test done");
   endtask
   initial begin
      {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, wb_ready} = 3'h0;
      writeback_invalidate_instr = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
      {cache_policy_strap, snoop_address_strobe_n, flush_req_n} = 3'h3;
      s_axi_wstrb = 4'hF;
      snoop_line_addr = LN;
      repeat (20) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (8) @(posedge ref_clk);
      t_reset;
      t_read;
      t_wback;
      t_flush;
      finish_test;
   end
endmodule
